//--- design/overflow_tracker.sv
// per-channel capture overflow flag with deferred update
`timescale 1ns/1ps

module overflow_tracker (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire timer_status_pkg::chan_mode_t mode,
	input  wire logic                         capture,
	input  wire logic                         wrap,
	output logic                              flag,
	output logic                              set_pulse
);

	logic pending;       // wrap seen since the last capture
	logic next_pending;
	logic next_flag;
	logic next_set;

	// flag moves only at captures; a wrap is merely remembered
	always_comb begin
		next_pending = pending | wrap;
		next_flag    = flag;
		next_set     = 1'b0;
		if (capture && timer_status_pkg::capture_mode(mode)) begin
			next_flag    = pending | wrap;
			next_set     = pending | wrap;
			next_pending = 1'b0;
		end else if (capture) begin
			// other modes drop the record too
			next_pending = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending   <= 1'b0;
			flag      <= 1'b0;
			set_pulse <= 1'b0;
		end else begin
			pending   <= next_pending;
			flag      <= next_flag;
			set_pulse <= next_set;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_no_set_other: assert property (
		!timer_status_pkg::capture_mode(mode) |=> !$rose(flag))
		else $error("flag set outside capture modes");
	a_wrap_no_change: assert property (
		wrap && !capture |=> $stable(flag))
		else $error("flag changed at wrap");
	a_capture_sets: assert property (
		capture && timer_status_pkg::capture_mode(mode) && wrap
		|=> flag && set_pulse)
		else $error("capture after wrap did not set flag");
	a_capture_clears: assert property (
		capture && timer_status_pkg::capture_mode(mode) && !wrap
		&& !pending |=> !flag)
		else $error("clean capture did not clear flag");

endmodule

//--- design/timer_status_flags.sv
// channel enable status and capture overflow flags behind apb
//
// Contract
// - overflow flag updates only in capture modes
// - capture after a wrap sets the flag
// - capture without wrap clears the flag
// - wrap alone never changes the flag
// - overflow status readable whole or low byte
// - start trigger one sets enable bit
// - stop trigger one clears enable bit
// - enable bit n at bit n; rest zero
// - upper halves of 1, 3 at 9, 11
// - split mode low bits show lower halves
// - enable register read-only, reset to zero
// - trigger bits self-clear and read zero
// - codes 010 and 110 select capture
`timescale 1ns/1ps
`include "timer_status_regs.svh"

module timer_status_flags #(
	parameter int CHANNELS = `TSF_DEF_CHANNELS
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [`TSF_ADDR_W-1:0]        paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire timer_status_pkg::chan_mode_t  chan_mode [CHANNELS],
	input  wire logic [CHANNELS-1:0]           capture_event,
	input  wire logic [CHANNELS-1:0]           counter_wrap,
	input  wire logic                          split_chan1,
	input  wire logic                          split_chan3,
	output logic      [15:0]                   channel_enable_status,
	output logic      [CHANNELS-1:0]           capture_overflow_flag,
	output logic                               irq
);

	if (CHANNELS != 4 && CHANNELS != 8) begin : g_bad_channels
		$error("CHANNELS must be 4 or 8");
	end

	localparam int U1 = `TSF_UPPER1_BIT;
	localparam int U3 = `TSF_UPPER3_BIT;

	// implemented enable bits: channels plus the two upper halves
	localparam logic [15:0] VALID_MASK =
		16'((16'h1 << CHANNELS) - 16'h1) |
		(16'h1 << U1) | (16'h1 << U3);

	// byte-lane gated trigger bits of a write
	function automatic logic [15:0] trig_bits(
		input logic [31:0] wdata,
		input logic [3:0]  strb);
		trig_bits = {strb[1] ? wdata[15:8] : 8'h00,
			strb[0] ? wdata[7:0] : 8'h00};
	endfunction

	logic [CHANNELS-1:0]      irq_stat;     // sticky overflow events
	logic [CHANNELS-1:0]      irq_mask;     // one lets a bit reach irq
	logic [CHANNELS-1:0]      ovf_set;      // set pulses from trackers
	logic [15:0]              next_enable;
	logic [CHANNELS-1:0]      next_stat;
	logic [CHANNELS-1:0]      next_mask;
	logic                     next_irq;
	logic [31:0]              next_prdata;
	logic                     next_pready;
	logic                     next_pslverr;
	logic                     access;       // access phase waiting
	logic                     done;         // transfer completes now
	logic [15:0]              start_bits;
	logic [15:0]              stop_bits;
	logic [15:0]              split_gate;
	logic [`TSF_ADDR_W-1:0]   ovf_off;
	logic                     ovf_hit;
	logic [31:0]              rdata;
	logic                     mapped;

	// one flag tracker per channel
	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		overflow_tracker u_trk (
			.pclk      (pclk),
			.presetn   (presetn),
			.mode      (chan_mode[c]),
			.capture   (capture_event[c]),
			.wrap      (counter_wrap[c]),
			.flag      (capture_overflow_flag[c]),
			.set_pulse (ovf_set[c])
		);
	end

	assign access = psel && penable && !pready;
	assign done   = psel && penable && pready;

	// read mux and decode, sampled one cycle into the access phase
	always_comb begin
		rdata   = 32'h0;
		mapped  = 1'b1;
		ovf_off = paddr - `TSF_OVF_BASE_OFFS;
		ovf_hit = (paddr >= `TSF_OVF_BASE_OFFS) &&
			(ovf_off < `TSF_ADDR_W'(4 * CHANNELS)) &&
			(ovf_off[1:0] == 2'h0);
		case (paddr)
			`TSF_ENABLE_OFFS: begin
				rdata[15:0] = channel_enable_status;
			end
			`TSF_START_OFFS, `TSF_STOP_OFFS: begin
				rdata = 32'h0;
			end
			`TSF_IRQ_STAT_OFFS: begin
				rdata[CHANNELS-1:0] = irq_stat;
			end
			`TSF_IRQ_MASK_OFFS: begin
				rdata[CHANNELS-1:0] = irq_mask;
			end
			default: begin
				// overflow word, flag in the low byte
				if (ovf_hit)
					rdata[`TSF_OVF_FLAG_BIT] =
						capture_overflow_flag[ovf_off[4:2]];
				else
					mapped = 1'b0;
			end
		endcase
	end

	// register next values; writes and read-clear act on done
	always_comb begin
		next_enable  = channel_enable_status;
		next_mask    = irq_mask;
		next_prdata  = prdata;
		next_pready  = access;
		next_pslverr = 1'b0;
		start_bits   = 16'h0;
		stop_bits    = 16'h0;
		split_gate     = VALID_MASK;
		split_gate[U1] = split_chan1;
		split_gate[U3] = split_chan3;
		if (access) begin
			next_prdata  = pwrite ? 32'h0 : rdata;
			next_pslverr = !mapped;
		end
		if (done && pwrite) begin
			if (paddr == `TSF_START_OFFS)
				start_bits = trig_bits(pwdata, pstrb) & split_gate;
			if (paddr == `TSF_STOP_OFFS)
				stop_bits = trig_bits(pwdata, pstrb) & split_gate;
			if (paddr == `TSF_IRQ_MASK_OFFS && pstrb[0])
				next_mask = pwdata[CHANNELS-1:0];
		end
		next_enable = next_enable | start_bits;
		// stop clears, wins on a tie
		next_enable = next_enable & ~stop_bits;
		next_enable = next_enable & VALID_MASK;
		// bits 1 and 3 serve lower halves
		// clear only what the read returned, so a new event survives
		next_stat = irq_stat;
		if (done && !pwrite && paddr == `TSF_IRQ_STAT_OFFS)
			next_stat = irq_stat & ~prdata[CHANNELS-1:0];
		next_stat = next_stat | ovf_set;
		next_irq  = |(next_stat & next_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_enable_status <= `TSF_ENABLE_RESET;
			irq_stat              <= CHANNELS'(`TSF_IRQ_RESET);
			irq_mask              <= CHANNELS'(`TSF_IRQ_RESET);
			irq                   <= 1'b0;
			prdata                <= 32'h0;
			pready                <= 1'b0;
			pslverr               <= 1'b0;
		end else begin
			channel_enable_status <= next_enable;
			irq_stat              <= next_stat;
			irq_mask              <= next_mask;
			irq                   <= next_irq;
			prdata                <= next_prdata;
			pready                <= next_pready;
			pslverr               <= next_pslverr;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a write transfer to an address, completing at pready
	sequence s_write_done(logic [`TSF_ADDR_W-1:0] a);
		done && pwrite && paddr == a;
	endsequence

	a_ready_answer: assert property (
		access |=> pready ##1 !pready)
		else $error("pready not one cycle after access");
	a_start_sets: assert property (
		s_write_done(`TSF_START_OFFS) ##0 pstrb[0] && pwdata[0]
		|=> channel_enable_status[0])
		else $error("start trigger did not enable channel 0");
	a_stop_clears: assert property (
		s_write_done(`TSF_STOP_OFFS) ##0 pstrb[0] && pwdata[0]
		|=> !channel_enable_status[0])
		else $error("stop trigger did not stop channel 0");
	a_absent_zero: assert property (
		(channel_enable_status & ~VALID_MASK) == 16'h0)
		else $error("unimplemented enable bit set");
	a_upper_split: assert property (
		$rose(channel_enable_status[U1]) |-> $past(split_chan1))
		else $error("upper half 1 enabled without split");
	a_trig_read_zero: assert property (
		access && !pwrite && paddr == `TSF_STOP_OFFS
		|=> pready && prdata == 32'h0)
		else $error("trigger register read nonzero");
	a_ro_enable: assert property (
		s_write_done(`TSF_ENABLE_OFFS) |=> $stable(channel_enable_status))
		else $error("enable status changed by direct write");
	a_irq_sticky: assert property (
		|ovf_set |=> (irq_stat & $past(ovf_set)) == $past(ovf_set))
		else $error("overflow event lost");

	// a read access phase at one address
	sequence s_read_access(logic [`TSF_ADDR_W-1:0] a);
		access && !pwrite && paddr == a;
	endsequence

	// upper half 3 needs split mode
	a_upper3_split: assert property (
		$rose(channel_enable_status[U3]) |-> $past(split_chan3))
		else $error("upper half 3 enabled without split");

	a_start_upper: assert property (
		s_write_done(`TSF_START_OFFS) ##0 pstrb[1] && pwdata[U1]
		&& split_chan1 |=> channel_enable_status[U1])
		else $error("start did not enable upper half 1");

	a_stop_upper: assert property (
		s_write_done(`TSF_STOP_OFFS) ##0 pstrb[1] && pwdata[U1]
		&& split_chan1 |=> !channel_enable_status[U1])
		else $error("stop left upper half 1 enabled");

	a_lower_half: assert property (
		s_write_done(`TSF_START_OFFS) ##0 pstrb[0] && pwdata[1]
		&& split_chan1 |=> channel_enable_status[1])
		else $error("split start did not enable lower half 1");

	a_enable_hold: assert property (
		!(done && pwrite && (paddr == `TSF_START_OFFS ||
		paddr == `TSF_STOP_OFFS)) |=> $stable(channel_enable_status))
		else $error("enable status moved without a trigger");

	a_ovf_read: assert property (
		s_read_access(`TSF_OVF_BASE_OFFS) |=> pready &&
		prdata == {31'h0, $past(capture_overflow_flag[0])})
		else $error("overflow status read wrong");

	a_start_read_zero: assert property (
		s_read_access(`TSF_START_OFFS) |=> pready && prdata == 32'h0)
		else $error("start register read nonzero");

	// unmapped addresses answer with error
	a_unmapped_err: assert property (
		access && !mapped |=> pready && pslverr)
		else $error("unmapped access without error");

	// mapped addresses answer cleanly
	a_mapped_ok: assert property (
		access && mapped |=> pready && !pslverr)
		else $error("mapped access flagged as error");

	// pready rises only after an access phase
	a_ready_cause: assert property (
		$rose(pready) |-> $past(access))
		else $error("pready raised without an access");

	// irq follows unmasked sticky bits
	a_irq_level: assert property (
		irq == |(irq_stat & irq_mask))
		else $error("irq disagrees with status and mask");

	// status read clears what it returned; a new event would win
	a_read_clear: assert property (
		done && !pwrite && paddr == `TSF_IRQ_STAT_OFFS
		&& ovf_set == '0
		|=> (irq_stat & $past(prdata[CHANNELS-1:0])) == '0)
		else $error("status bits survived their read");

endmodule

//--- design/timer_status_pkg.sv
// types and mode decoding shared by the status block files
`include "timer_status_regs.svh"

package timer_status_pkg;

	// three-bit channel operating mode
	typedef logic [2:0] chan_mode_t;

	// capture and capture-one-count are the up-counting capture modes
	function automatic logic capture_mode(input chan_mode_t mode);
		capture_mode = (mode == `TSF_MODE_CAPTURE) ||
			(mode == `TSF_MODE_CAPT_ONE);
	endfunction

endpackage

//--- design/timer_status_regs.svh
// register map, field positions and reset values of the status block
`ifndef TIMER_STATUS_REGS_SVH
`define TIMER_STATUS_REGS_SVH

`define TSF_ADDR_W          20
`define TSF_ENABLE_OFFS     20'hf01b0
`define TSF_START_OFFS      20'hf01b4
`define TSF_STOP_OFFS       20'hf01b8
`define TSF_OVF_BASE_OFFS   20'hf01c0
`define TSF_IRQ_STAT_OFFS   20'hf01e0
`define TSF_IRQ_MASK_OFFS   20'hf01e4

`define TSF_UPPER1_BIT      9
`define TSF_UPPER3_BIT      11
`define TSF_OVF_FLAG_BIT    0

`define TSF_MODE_CAPTURE    3'h2
`define TSF_MODE_CAPT_ONE   3'h6

`define TSF_ENABLE_RESET    16'h0000
`define TSF_IRQ_RESET       8'h00
`define TSF_DEF_CHANNELS    8

`endif

//--- test/timer_status_flags_test.sv
// self-checking bench for the timer status flag block
`timescale 1ns/1ps
`include "timer_status_regs.svh"

module timer_status_flags_test;
	logic                         pclk;            // 200 MHz bus clock
	logic                         presetn;         // async reset, low
	logic                         psel;            // apb select
	logic                         penable;         // apb access phase
	logic                         pwrite;          // apb direction
	logic [19:0]                  paddr;           // byte address
	logic [31:0]                  pwdata;          // write data
	logic [3:0]                   pstrb;           // byte lanes
	logic [31:0]                  prdata;          // read data
	logic                         pready;          // one-cycle answer
	logic                         pslverr;         // unmapped answer
	timer_status_pkg::chan_mode_t chan_mode [8];   // per-channel mode
	logic [7:0]                   capture_event;   // capture pulses
	logic [7:0]                   counter_wrap;    // overflow pulses
	logic                         split_chan1;     // channel 1 split
	logic                         split_chan3;     // channel 3 split
	logic [15:0]                  channel_enable_status; // enable copy
	logic [7:0]                   capture_overflow_flag; // flag per chan
	logic                         irq;             // level interrupt
	int                           bad_count;       // mismatches seen
	int                           tests_run;       // comparisons made
	logic [31:0]                  rd_data;         // last read word
	logic                         rd_err;          // last error bit

	timer_status_flags #(.CHANNELS(8)) dut_u (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chan_mode(chan_mode), .capture_event(capture_event),
		.counter_wrap(counter_wrap), .split_chan1(split_chan1),
		.split_chan3(split_chan3),
		.channel_enable_status(channel_enable_status),
		.capture_overflow_flag(capture_overflow_flag), .irq(irq));

	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// verdict and end of run
	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one comparison, four-state exact
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s got %h want %h", $time, what, got,
				exp);
		end
	endtask

	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [19:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a hung slave ends the run
		if (n >= 20) begin
			bad_count++;
			wrap_up();
		end
		rd_data = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// read and compare data, expecting no error
	task automatic rd(input logic [19:0] a, input logic [31:0] exp,
		input string what);
		apb(1'b0, a, 32'h0);
		check(rd_data, exp, what);
		check({31'h0, rd_err}, 32'h0, "error bit");
	endtask

	// wrap and capture pulses on one channel, then let the flag land
	task automatic ev(input int ch, input logic w, input logic c);
		@(posedge pclk);
		counter_wrap[ch]  <= w;
		capture_event[ch] <= c;
		@(posedge pclk);
		counter_wrap[ch]  <= 1'b0;
		capture_event[ch] <= 1'b0;
		@(posedge pclk);
		#1;
	endtask

	initial begin
		bad_count = 0;
		tests_run = 0;
		{presetn, psel, penable, pwrite} = 4'h0;
		{paddr, pwdata, pstrb} = '0;
		{capture_event, counter_wrap} = 16'h0000;
		{split_chan1, split_chan3} = 2'b00;
		for (int i = 0; i < 8; i++) chan_mode[i] = 3'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(`TSF_ENABLE_OFFS, 32'h0, "enable reset");
		rd(`TSF_OVF_BASE_OFFS, 32'h0, "flag reset");
		apb(1'b1, `TSF_START_OFFS, 32'h0000_00ff);
		rd(`TSF_ENABLE_OFFS, 32'h0000_00ff, "start all");
		rd(`TSF_START_OFFS, 32'h0, "start reads zero");
		apb(1'b1, `TSF_ENABLE_OFFS, 32'h0);
		rd(`TSF_ENABLE_OFFS, 32'h0000_00ff, "enable read-only");
		apb(1'b1, `TSF_STOP_OFFS, 32'h0000_000f);
		rd(`TSF_ENABLE_OFFS, 32'h0000_00f0, "stop low");
		rd(`TSF_STOP_OFFS, 32'h0, "stop reads zero");
		// upper-half and absent bits ignored without split mode
		apb(1'b1, `TSF_START_OFFS, 32'h0000_ff00);
		rd(`TSF_ENABLE_OFFS, 32'h0000_00f0, "no split upper");
		split_chan1 <= 1'b1;
		split_chan3 <= 1'b1;
		apb(1'b1, `TSF_START_OFFS, 32'h0000_0a02);
		rd(`TSF_ENABLE_OFFS, 32'h0000_0af2, "upper halves");
		apb(1'b1, `TSF_STOP_OFFS, 32'h0000_0200);
		rd(`TSF_ENABLE_OFFS, 32'h0000_08f2, "upper 1 off");
		check({16'h0, channel_enable_status}, 32'h08f2, "port");
		apb(1'b0, 20'hf01fc, 32'h0);
		check({31'h0, rd_err}, 32'h1, "unmapped error");
		chan_mode[0] <= `TSF_MODE_CAPTURE;
		chan_mode[1] <= `TSF_MODE_CAPT_ONE;
		ev(0, 1'b1, 1'b0);
		check({31'h0, capture_overflow_flag[0]}, 32'h0, "wrap");
		ev(0, 1'b0, 1'b1);
		check({31'h0, capture_overflow_flag[0]}, 32'h1, "set");
		rd(`TSF_OVF_BASE_OFFS, 32'h1, "status word");
		ev(0, 1'b0, 1'b1);
		check({31'h0, capture_overflow_flag[0]}, 32'h0, "clear");
		ev(1, 1'b1, 1'b1);
		check({31'h0, capture_overflow_flag[1]}, 32'h1, "mode 6");
		// every non-capture code must leave the flag alone
		for (int m = 0; m < 8; m++) begin
			if (m == 2 || m == 6) continue;
			chan_mode[2] <= 3'(m);
			ev(2, 1'b1, 1'b1);
			check({31'h0, capture_overflow_flag[2]}, 32'h0, "mode");
		end
		check({31'h0, irq}, 32'h0, "masked");
		rd(`TSF_IRQ_STAT_OFFS, 32'h3, "irq status");
		apb(1'b1, `TSF_IRQ_MASK_OFFS, 32'h1);
		ev(0, 1'b1, 1'b1);
		@(posedge pclk);
		#1;
		check({31'h0, irq}, 32'h1, "irq raised");
		rd(`TSF_IRQ_STAT_OFFS, 32'h1, "irq status ch0");
		repeat (2) @(posedge pclk);
		#1;
		check({31'h0, irq}, 32'h0, "irq cleared");
		// a mid-run reset drops flags, irq and enables
		ev(0, 1'b1, 1'b1);
		check({31'h0, capture_overflow_flag[0]}, 32'h1, "pre-reset");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		check({31'h0, capture_overflow_flag[0]}, 32'h0, "reset");
		check({31'h0, irq}, 32'h0, "reset irq");
		presetn <= 1'b1;
		rd(`TSF_ENABLE_OFFS, 32'h0, "reset enable");
		wrap_up();
	end
endmodule
